// >>> core/arg_pkg.sv
// Constants shared by the result and pin control register bank.
package arg_pkg;
   // Register addresses of the eight result registers, in slot order, and of the pin control byte.
   localparam logic [7:0] ADDR_CURRENT_RESULT = 8'h40;
   localparam logic [7:0] ADDR_INTERNAL_TEMP_RESULT = 8'h44;
   localparam logic [7:0] ADDR_EXTERNAL_TEMP_RESULT = 8'h48;
   localparam logic [7:0] ADDR_PACK_VOLTAGE_RESULT = 8'h4C;
   localparam logic [7:0] ADDR_CELL1_VOLTAGE_RESULT = 8'h50;
   localparam logic [7:0] ADDR_CELL2_VOLTAGE_RESULT = 8'h54;
   localparam logic [7:0] ADDR_OFFSET_RESULT = 8'h58;
   localparam logic [7:0] ADDR_AUXILIARY_RESULT = 8'h5C;
   localparam logic [7:0] ADDR_RESULT_FIRST = ADDR_CURRENT_RESULT;
   localparam logic [7:0] ADDR_RESULT_LAST = ADDR_AUXILIARY_RESULT;
   localparam int RESULT_STRIDE_LOG2 = 2;
   localparam int NUM_SLOTS = 8;
   localparam logic [7:0] ADDR_PIN_IO_CONTROL = 8'h53;

   // Result register fields.
   localparam int RESULT_SIGN_BIT = 15;
   localparam int RESULT_MAG_MSB = 14;
   localparam int MAG_WIDTH = 15;
   localparam int RES_MIN_BITS = 8;
   localparam logic [15:0] RESULT_RESET = 16'h0000;

   // Pin control byte fields.
   localparam int PIO_PIN1_INPUT_ENABLE = 7;
   localparam int PIO_PIN0_INPUT_ENABLE = 6;
   localparam int PIO_PIN1_INPUT_VALUE = 5;
   localparam int PIO_PIN0_INPUT_VALUE = 4;
   localparam int PIO_PIN1_DRIVE_TYPE = 3;
   localparam int PIO_PIN0_DRIVE_TYPE = 2;
   localparam int PIO_PIN1_OUTPUT_DATA = 1;
   localparam int PIO_PIN0_OUTPUT_DATA = 0;
   localparam logic [7:0] PIO_WRITABLE_MASK = 8'hCF;
   localparam logic [7:0] PIO_RESET = 8'h03;
endpackage : arg_pkg

// >>> core/arg_pin_input.sv
// Two-flop synchroniser for one multipurpose pin with input gating.
`timescale 1ns/1ps
module arg_pin_input (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst_n,
   // Pin level and gate.
   input wire logic pin_in,
   input wire logic input_enable,
   // Gated synchronised value.
   output logic value
);
   logic meta_ff;
   logic sync_ff;
   logic value_ff;
   logic nxt_value;

   // A disabled buffer reads as zero; only the third flop, value_ff, is gated.
   always_comb
   begin
      nxt_value = sync_ff & input_enable;
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         meta_ff <= 1'b0;
         sync_ff <= 1'b0;
         value_ff <= 1'b0;
      end
      else
      begin
         meta_ff <= pin_in;
         sync_ff <= meta_ff;
         value_ff <= nxt_value;
      end
   end

   assign value = value_ff;
endmodule : arg_pin_input

// >>> core/arg_result_regs.sv
// Conversion result registers and the multipurpose pin control byte.
// What this block does
// - Eight 16-bit result registers, one per conversion slot, keep the latest measurement.
// - Results sit at 0x40 to 0x5C, four apart, in fixed channel order.
// - Bit 15 gives polarity: one negative, zero positive.
// - Bits 14..0 hold unsigned magnitude, zeros zero, ones full scale.
// - Magnitude is left justified; host ignores bits beyond the resolution.
// - The pin control byte answers at address 0x53.
// - Pin 0 input enable at one makes pin 0 a digital input.
// - Pin 0 input enable at zero gates its buffer; input value reads zero.
// - Three-bit resolution picks 8 to 15 magnitude bits, one per step.
`timescale 1ns/1ps
module arg_result_regs (
   // Clock and reset.
   input wire logic CLK_SYS,
   input wire logic RST_N,
   // Register access port from the serial interface.
   input wire logic [7:0] REG_ADDR,
   input wire logic REG_WR,
   input wire logic [7:0] REG_WDATA,
   input wire logic REG_RD,
   output logic [15:0] REG_RDATA,
   output logic REG_RVALID,
   // Finished conversions from the converter sequencer.
   input wire logic CONV_VALID,
   input wire logic [2:0] CONV_SLOT,
   input wire logic CONV_SIGN,
   input wire logic [14:0] CONV_MAG,
   input wire logic [2:0] CONV_RES,
   // Multipurpose pin 0, shared with the thermistor input.
   input wire logic PIN0_IN,
   output logic PIN0_OUT,
   output logic PIN0_OE,
   output logic PIN0_PULLUP,
   // Multipurpose pin 1, shared with the cell 2 input.
   input wire logic PIN1_IN,
   output logic PIN1_OUT,
   output logic PIN1_OE,
   output logic PIN1_PULLUP
);
   logic [15:0] result_ff [arg_pkg::NUM_SLOTS];
   logic [15:0] nxt_result [arg_pkg::NUM_SLOTS];
   logic [7:0] pio_ff;
   logic [7:0] nxt_pio;
   logic [15:0] rdata_ff;
   logic [15:0] nxt_rdata;
   logic rvalid_ff;
   logic nxt_rvalid;
   logic [1:0] out_ff;
   logic [1:0] nxt_out;
   logic [1:0] oe_ff;
   logic [1:0] nxt_oe;
   logic [1:0] pull_ff;
   logic [1:0] nxt_pull;
   logic pin0_value;
   logic pin1_value;
   logic [14:0] res_mask;
   logic [7:0] pio_view;
   logic [2:0] rd_slot;
   logic rd_is_result;

   arg_pin_input u_pin0 (
      .clk(CLK_SYS),
      .rst_n(RST_N),
      .pin_in(PIN0_IN),
      .input_enable(pio_ff[arg_pkg::PIO_PIN0_INPUT_ENABLE]),
      .value(pin0_value)
   );

   arg_pin_input u_pin1 (
      .clk(CLK_SYS),
      .rst_n(RST_N),
      .pin_in(PIN1_IN),
      .input_enable(pio_ff[arg_pkg::PIO_PIN1_INPUT_ENABLE]),
      .value(pin1_value)
   );

   // Keeps the top 8 + CONV_RES magnitude bits and clears the rest.
   always_comb
   begin
      res_mask = 15'h7FFF << (5'(arg_pkg::MAG_WIDTH - arg_pkg::RES_MIN_BITS) - {2'b00, CONV_RES});
   end

   // Result capture; the slot number is the select code the host set up.
   always_comb
   begin
      for (int i = 0; i < arg_pkg::NUM_SLOTS; i++)
      begin
         nxt_result[i] = result_ff[i];
      end
      if (CONV_VALID)
      begin
         nxt_result[CONV_SLOT] = {CONV_SIGN, CONV_MAG & res_mask};
      end
   end

   // Pin control byte; input value bits are read only and come from the pins.
   always_comb
   begin
      nxt_pio = pio_ff;
      if (REG_WR && (REG_ADDR == arg_pkg::ADDR_PIN_IO_CONTROL))
      begin
         nxt_pio = REG_WDATA & arg_pkg::PIO_WRITABLE_MASK;
      end
      pio_view = pio_ff;
      pio_view[arg_pkg::PIO_PIN0_INPUT_VALUE] = pin0_value;
      pio_view[arg_pkg::PIO_PIN1_INPUT_VALUE] = pin1_value;
   end

   // Read decode; results occupy aligned words, the pin control byte answers at 0x53, everything else reads zero.
   always_comb
   begin
      rd_is_result = (REG_ADDR >= arg_pkg::ADDR_RESULT_FIRST) && (REG_ADDR <= arg_pkg::ADDR_RESULT_LAST)
         && (REG_ADDR[arg_pkg::RESULT_STRIDE_LOG2-1:0] == 2'b00);
      rd_slot = 3'(REG_ADDR[7:arg_pkg::RESULT_STRIDE_LOG2]
         - arg_pkg::ADDR_RESULT_FIRST[7:arg_pkg::RESULT_STRIDE_LOG2]);
      nxt_rvalid = REG_RD;
      nxt_rdata = rdata_ff;
      if (REG_RD)
      begin
         if (REG_ADDR == arg_pkg::ADDR_PIN_IO_CONTROL)
         begin
            nxt_rdata = {8'h00, pio_view};
         end
         else if (rd_is_result)
         begin
            nxt_rdata = result_ff[rd_slot];
         end
         else
         begin
            nxt_rdata = 16'h0000;
         end
      end
   end

   // Pin drivers: push-pull drives the data, open-drain only pulls low.
   always_comb
   begin
      for (int p = 0; p < 2; p++)
      begin
         logic push_pull;
         logic data;
         push_pull = 1'b0;
         data = 1'b0;
         push_pull = (p == 0) ? pio_ff[arg_pkg::PIO_PIN0_DRIVE_TYPE] : pio_ff[arg_pkg::PIO_PIN1_DRIVE_TYPE];
         data = (p == 0) ? pio_ff[arg_pkg::PIO_PIN0_OUTPUT_DATA] : pio_ff[arg_pkg::PIO_PIN1_OUTPUT_DATA];
         nxt_out[p] = push_pull ? data : 1'b0;
         nxt_oe[p] = push_pull ? 1'b1 : ~data;
         nxt_pull[p] = ~push_pull;
      end
   end

   // Results read as zero until the first conversion of each slot.
   always_ff @(posedge CLK_SYS)
   begin
      if (!RST_N)
      begin
         for (int i = 0; i < arg_pkg::NUM_SLOTS; i++)
         begin
            result_ff[i] <= arg_pkg::RESULT_RESET;
         end
      end
      else
      begin
         result_ff <= nxt_result;
      end
   end

   always_ff @(posedge CLK_SYS)
   begin
      if (!RST_N)
      begin
         pio_ff <= arg_pkg::PIO_RESET;
      end
      else
      begin
         pio_ff <= nxt_pio;
      end
   end

   // Read data holds the last answer until the next read.
   always_ff @(posedge CLK_SYS)
   begin
      if (!RST_N)
      begin
         rdata_ff <= 16'h0000;
         rvalid_ff <= 1'b0;
      end
      else
      begin
         rdata_ff <= nxt_rdata;
         rvalid_ff <= nxt_rvalid;
      end
   end

   // Reset leaves both pins released with their weak pull-ups on.
   always_ff @(posedge CLK_SYS)
   begin
      if (!RST_N)
      begin
         out_ff <= 2'h0;
         oe_ff <= 2'h0;
         pull_ff <= 2'h3;
      end
      else
      begin
         out_ff <= nxt_out;
         oe_ff <= nxt_oe;
         pull_ff <= nxt_pull;
      end
   end

   assign REG_RDATA = rdata_ff;
   assign REG_RVALID = rvalid_ff;
   assign PIN0_OUT = out_ff[0];
   assign PIN0_OE = oe_ff[0];
   assign PIN0_PULLUP = pull_ff[0];
   assign PIN1_OUT = out_ff[1];
   assign PIN1_OE = oe_ff[1];
   assign PIN1_PULLUP = pull_ff[1];
endmodule : arg_result_regs

// >>> testbench/arg_result_regs_checker.sv
// Checker for the result and pin control register bank.
`timescale 1ns/1ps
module arg_checker (
   // Watched ports.
   input wire logic CLK_SYS,
   input wire logic RST_N,
   input wire logic [7:0] REG_ADDR,
   input wire logic REG_WR,
   input wire logic [7:0] REG_WDATA,
   input wire logic REG_RD,
   input wire logic [15:0] REG_RDATA,
   input wire logic REG_RVALID,
   input wire logic PIN0_OUT,
   input wire logic PIN0_OE,
   input wire logic PIN0_PULLUP
);
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!RST_N);
   sequence s_wr(b);
      (REG_WR && REG_ADDR == 8'h53 && b) ##1 !REG_WR;
   endsequence
   property p_rv; 1'b1 |=> REG_RVALID == $past(REG_RD); endproperty
   a_rv: assert property (p_rv) else $error("read answer timing wrong");
   property p_hold; !REG_RD |=> $stable(REG_RDATA); endproperty
   a_hold: assert property (p_hold) else $error("read data moved");
   property p_unm; REG_RD && REG_ADDR[1:0] != 2'h0 && REG_ADDR != 8'h53 |=> REG_RDATA == 16'h0000; endproperty
   a_unm: assert property (p_unm) else $error("unmapped read not zero");
   property p_pio; REG_RD && REG_ADDR == 8'h53 |=> REG_RDATA[15:8] == 8'h00; endproperty
   a_pio: assert property (p_pio) else $error("control read upper byte");
   property p_pp; s_wr(REG_WDATA[2]) |=> PIN0_OE && !PIN0_PULLUP && PIN0_OUT == $past(REG_WDATA[0], 2); endproperty
   a_pp: assert property (p_pp) else $error("push-pull pin wrong");
   property p_od; s_wr(!REG_WDATA[2]) |=> PIN0_PULLUP && !PIN0_OUT && PIN0_OE == !$past(REG_WDATA[0], 2); endproperty
   a_od: assert property (p_od) else $error("open-drain pin wrong");
   property p_ie0; s_wr(!REG_WDATA[6]) ##1 (REG_RD && REG_ADDR == 8'h53) |=> !REG_RDATA[4]; endproperty
   a_ie0: assert property (p_ie0) else $error("gated input read one");
   property p_pst; !REG_WR ##1 !REG_WR |=> $stable({PIN0_OUT, PIN0_OE, PIN0_PULLUP}); endproperty
   a_pst: assert property (p_pst) else $error("pin moved without write");
endmodule : arg_checker

bind arg_result_regs arg_checker u_chk (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR),
   .REG_WDATA(REG_WDATA), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID),
   .PIN0_OUT(PIN0_OUT), .PIN0_OE(PIN0_OE), .PIN0_PULLUP(PIN0_PULLUP));

// >>> testbench/arg_host_model.sv
// Host model that issues register reads and writes.
`timescale 1ns/1ps
module arg_host_model (
   // Clock and answer.
   input wire logic clk,
   input wire logic [15:0] rdata,
   // Request.
   output logic [7:0] addr,
   output logic wr,
   output logic [7:0] wdata,
   output logic rd
);
   // Slot input selects are taken as already programmed in slot order.
   initial
   begin
      addr = 8'hFF;
      wdata = 8'hFF;
      wr = 1'b0;
      rd = 1'b0;
   end
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      #1;
      addr = a;
      wdata = d;
      wr = 1'b1;
      @(posedge clk);
      #1;
      wr = 1'b0;
      addr = ~a;
      wdata = ~d;
   endtask : wr_reg
   task automatic rd_reg(input logic [7:0] a, output logic [15:0] d);
      @(posedge clk);
      #1;
      addr = a;
      rd = 1'b1;
      @(posedge clk);
      #1;
      rd = 1'b0;
      addr = ~a;
      d = rdata;
   endtask : rd_reg
endmodule : arg_host_model

// >>> testbench/arg_result_regs_bench.sv
// Self-checking bench for the result and pin control register bank.
`timescale 1ns/1ps
module arg_result_regs_bench;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic cv = 1'b0;
   logic [2:0] cs = 3'h0;
   logic sg = 1'b0;
   logic [14:0] cm = 15'h0000;
   logic [2:0] cr = 3'h0;
   logic p0x = 1'b1;
   logic p1x = 1'b1;
   wire logic [7:0] ra, wd;
   wire logic rw, rr, rv, p0o, p0e, p0u, p1o, p1e, p1u;
   wire logic [15:0] rdat;
   logic [15:0] d;
   int fails = 0;
   int checks = 0;
   always #2 clk = ~clk;
   arg_host_model u_host (.clk(clk), .rdata(rdat), .addr(ra), .wr(rw), .wdata(wd), .rd(rr));
   arg_result_regs dut (.CLK_SYS(clk), .RST_N(rst_n), .REG_ADDR(ra), .REG_WR(rw), .REG_WDATA(wd), .REG_RD(rr),
      .REG_RDATA(rdat), .REG_RVALID(rv), .CONV_VALID(cv), .CONV_SLOT(cs), .CONV_SIGN(sg), .CONV_MAG(cm),
      .CONV_RES(cr), .PIN0_IN(p0e ? p0o : p0x), .PIN0_OUT(p0o), .PIN0_OE(p0e), .PIN0_PULLUP(p0u),
      .PIN1_IN(p1e ? p1o : p1x), .PIN1_OUT(p1o), .PIN1_OE(p1e), .PIN1_PULLUP(p1u));
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      checks++;
      if (g !== e)
      begin
         fails++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic stop_test;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : stop_test
   task automatic conv(input logic [2:0] s, input logic g, input logic [14:0] m, input logic [2:0] r);
      @(posedge clk);
      #1;
      cv = 1'b1;
      cs = s;
      sg = g;
      cm = m;
      cr = r;
      @(posedge clk);
      #1;
      cv = 1'b0;
   endtask : conv
   task automatic t_reset;
      logic [7:0] um [4] = '{8'h41, 8'h5D, 8'h60, 8'h3C};
      u_host.rd_reg(8'h40, d);
      chk("result0", 16'h0000, d);
      chk("rvalid", 16'h0001, {15'h0000, rv});
      u_host.rd_reg(8'h53, d);
      chk("control", 16'h0003, d);
      foreach (um[i])
      begin
         u_host.rd_reg(um[i], d);
         chk("unmapped", 16'h0000, d);
      end
      @(posedge clk);
      #1;
      chk("rvalid_low", 16'h0000, {15'h0000, rv});
   endtask : t_reset
   task automatic t_map;
      for (int i = 0; i < 8; i++)
         conv(i[2:0], i[0], {i[2:0], 12'hA5C}, 3'h7);
      for (int i = 0; i < 8; i++)
      begin
         u_host.rd_reg(8'h40 + {i[3:0], 2'h0}, d);
         chk("result", {i[0], i[2:0], 12'hA5C}, d);
      end
   endtask : t_map
   task automatic t_res;
      for (int i = 0; i < 8; i++)
      begin
         conv(3'h2, 1'b1, 15'h7FFF, i[2:0]);
         u_host.rd_reg(8'h48, d);
         chk("masked", {1'b1, 15'h7FFF << (7 - i)}, d);
      end
   endtask : t_res
   task automatic t_pins;
      logic [21:0] tb [4] = '{{8'h53, 8'h0C, 3'h2, 3'h2}, {8'h53, 8'h0F, 3'h6, 3'h6},
         {8'h53, 8'h02, 3'h3, 3'h1}, {8'h52, 8'h0F, 3'h3, 3'h1}};
      foreach (tb[i])
      begin
         u_host.wr_reg(tb[i][21:14], tb[i][13:6]);
         repeat (2) @(posedge clk);
         #1;
         chk("pin0", {13'h0, tb[i][5:3]}, {13'h0, p0o, p0e, p0u});
         chk("pin1", {13'h0, tb[i][2:0]}, {13'h0, p1o, p1e, p1u});
      end
   endtask : t_pins
   task automatic t_input;
      u_host.wr_reg(8'h53, 8'hC3);
      repeat (5) @(posedge clk);
      u_host.rd_reg(8'h53, d);
      chk("in_on", 16'h00F3, d);
      u_host.wr_reg(8'h53, 8'h31);
      u_host.rd_reg(8'h53, d);
      chk("in_off", 16'h0001, d);
   endtask : t_input
   task automatic t_rerst;
      @(posedge clk);
      #1;
      rst_n = 1'b0;
      repeat (3) @(posedge clk);
      #1;
      rst_n = 1'b1;
      chk("pin_rst", 16'h0009, {10'h000, p0o, p0e, p0u, p1o, p1e, p1u});
      u_host.rd_reg(8'h48, d);
      chk("result_rst", 16'h0000, d);
      u_host.rd_reg(8'h53, d);
      chk("control_rst", 16'h0003, d);
   endtask : t_rerst
   initial
   begin
      repeat (20) @(posedge clk);
      #1;
      rst_n = 1'b1;
      t_reset();
      t_map();
      t_res();
      t_pins();
      t_input();
      t_rerst();
      stop_test();
   end
   initial
   begin
      repeat (5000) @(posedge clk);
      fails++;
      stop_test();
   end
endmodule : arg_result_regs_bench
